// *** verilog/lro_pkg.sv ***
// package for the load rejection output controller: constants, types, register map
// assumes one 200 MHz clock domain and a 32-bit AXI4-Lite register bus
package lro_pkg;
	localparam int NCH = 8;
	localparam int DW  = 16;

	// hold-mode codes
	localparam logic [2:0] HOLD_LAST = 3'h0;
	localparam logic [2:0] HOLD_MIN  = 3'h1;
	localparam logic [2:0] HOLD_MAX  = 3'h2;
	localparam logic [2:0] HOLD_USER = 3'h3;
	localparam logic [2:0] HOLD_ZERO = 3'h4;
	localparam logic [2:0] HOLD_RST  = HOLD_ZERO;
	localparam logic [DW-1:0] USER_RST = 16'h0000;

	// output codes in the converter's count space, per range
	localparam logic [DW-1:0] V_MIN  = 16'h8ccd;    // -11 V
	localparam logic [DW-1:0] V_MAX  = 16'h7333;    // +11 V
	localparam logic [DW-1:0] V_ZERO = 16'h0000;    // 0 V
	localparam logic [DW-1:0] I_MIN  = 16'hf830;    // 3.2 mA
	localparam logic [DW-1:0] I_MAX  = 16'h1f40;    // 20.8 mA
	localparam logic [DW-1:0] I_ZERO = 16'h0000;    // 4 mA

	// conversion timing
	localparam int CLK_MHZ    = 200;
	localparam int SLOW_US    = 250;
	localparam int FAST_US    = 10;
	localparam int SLOW_CYC   = SLOW_US * CLK_MHZ;
	localparam int FAST_CYC   = FAST_US * CLK_MHZ;
	localparam int CNT_W      = 16;

	// register byte offsets
	localparam logic [7:0] A_CTRL   = 8'h00;
	localparam logic [7:0] A_STAT   = 8'h04;
	localparam logic [7:0] A_IRQ    = 8'h08;
	localparam logic [7:0] A_MASK   = 8'h0c;
	localparam logic [7:0] A_CFG    = 8'h10;
	localparam logic [7:0] A_RANGE  = 8'h14;
	localparam logic [7:0] A_USER0  = 8'h20;
	localparam logic [7:0] A_OUT0   = 8'h40;
	// control fields
	localparam int C_RESTART = 0;
	localparam int C_FAST    = 1;
	// irq bits
	localparam int I_FAULT   = 0;
	localparam int I_RECOVER = 1;
	localparam int I_SCAN    = 2;
	localparam logic [2:0] MASK_RST = 3'h0;
	localparam logic [1:0] AXI_OK     = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;

	typedef struct packed {
		logic [2:0]    mode;
		logic          cur;     // 1: 4-20 mA range
		logic [DW-1:0] user;
	} lro_chcfg_s;

	typedef struct packed {
		logic          fast;
		logic [NCH-1:0] en;
		lro_chcfg_s [NCH-1:0] ch;
	} lro_cfg_s;

	function automatic logic [DW-1:0] lro_fault_val(input lro_chcfg_s c,
		input logic [DW-1:0] last);
		logic [DW-1:0] v;
		v = c.cur ? I_ZERO : V_ZERO;
		unique case (c.mode)
			HOLD_LAST: v = last;
			HOLD_MIN:  v = c.cur ? I_MIN : V_MIN;
			HOLD_MAX:  v = c.cur ? I_MAX : V_MAX;
			HOLD_USER: v = c.user;
			default:   v = c.cur ? I_ZERO : V_ZERO;
		endcase
		return v;
	endfunction
endpackage

// *** verilog/lro_scan.sv ***
// conversion scan timer: one slot per active channel, slot length by speed
// assumes cfg is stable between restarts
`timescale 1ns/1ps
`default_nettype none
module lro_scan import lro_pkg::*; (
	// clock and reset
	input  wire logic           ref_clk,
	input  wire logic           srst,
	input  wire logic           ce,
	// configuration
	input  wire logic           fast,
	input  wire logic [NCH-1:0] en,
	// scan events
	output logic [2:0]          slot,
	output logic                slot_pulse,
	output logic                scan_done
);
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] lim;
	logic [2:0]       last_en;

	always_comb begin
		lim = fast ? CNT_W'(FAST_CYC - 1) : CNT_W'(SLOW_CYC - 1);
		last_en = 3'h0;
		for (int i = 0; i < NCH; i++) begin
			if (en[i]) begin
				last_en = 3'(i);
			end
		end
	end

	// each active channel takes one per-point time, so the unit period scales with count
	// limit is compared with >= so a slow-to-fast restart cannot strand cnt above it
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cnt        <= '0;
			slot       <= 3'h0;
			slot_pulse <= 1'b0;
			scan_done  <= 1'b0;
		end else if (ce) begin
			slot_pulse <= 1'b0;
			scan_done  <= 1'b0;
			if (!en[slot]) begin
				slot <= (slot == last_en) ? 3'h0 : slot + 3'h1;       // skip idle
			end else if (cnt >= lim) begin
				cnt        <= '0;
				slot_pulse <= 1'b1;
				scan_done  <= (slot == last_en);
				slot       <= (slot == last_en) ? 3'h0 : slot + 3'h1;
			end else begin
				cnt <= cnt + CNT_W'(1);
			end
		end
	end
endmodule
`default_nettype wire

// *** verilog/lro_axil.sv ***
// AXI4-Lite slave shell: accepts aw/w in either order, one write and one read at a time
// assumes the owner answers reads combinationally from rd_addr
`timescale 1ns/1ps
`default_nettype none
module lro_axil import lro_pkg::*; (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        srst,
	input  wire logic        ce,
	// axi write
	input  wire logic [7:0]  s_awaddr,
	input  wire logic        s_awvalid,
	output logic             s_awready,
	input  wire logic [31:0] s_wdata,
	input  wire logic [3:0]  s_wstrb,
	input  wire logic        s_wvalid,
	output logic             s_wready,
	output logic [1:0]       s_bresp,
	output logic             s_bvalid,
	input  wire logic        s_bready,
	// axi read
	input  wire logic [7:0]  s_araddr,
	input  wire logic        s_arvalid,
	output logic             s_arready,
	output logic [31:0]      s_rdata,
	output logic [1:0]       s_rresp,
	output logic             s_rvalid,
	input  wire logic        s_rready,
	// register side
	output logic             wr_en,
	output logic [7:0]       wr_addr,
	output logic [31:0]      wr_data,
	output logic [3:0]       wr_strb,
	input  wire logic        wr_ok,
	output logic [7:0]       rd_addr,
	input  wire logic [31:0] rd_data,
	input  wire logic        rd_ok,
	output logic             rd_en
);
	logic have_a;
	logic have_w;

	assign rd_addr = s_araddr;
	assign rd_en   = ce && s_arvalid && s_arready;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			have_a    <= 1'b0;
			have_w    <= 1'b0;
			s_awready <= 1'b1;
			s_wready  <= 1'b1;
			s_bvalid  <= 1'b0;
			s_bresp   <= AXI_OK;
			wr_en     <= 1'b0;
			wr_addr   <= 8'h00;
			wr_data   <= 32'h0000_0000;
			wr_strb   <= 4'h0;
		end else if (ce) begin
			wr_en <= 1'b0;
			if (s_awvalid && s_awready) begin
				wr_addr   <= s_awaddr;
				have_a    <= 1'b1;
				s_awready <= 1'b0;
			end
			if (s_wvalid && s_wready) begin
				wr_data  <= s_wdata;
				wr_strb  <= s_wstrb;
				have_w   <= 1'b1;
				s_wready <= 1'b0;
			end
			if (have_a && have_w && !s_bvalid && !wr_en) begin
				wr_en <= 1'b1;
			end
			if (wr_en) begin
				s_bvalid <= 1'b1;
				s_bresp  <= wr_ok ? AXI_OK : AXI_SLVERR;
			end
			if (s_bvalid && s_bready) begin
				s_bvalid  <= 1'b0;
				have_a    <= 1'b0;
				have_w    <= 1'b0;
				s_awready <= 1'b1;
				s_wready  <= 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			s_arready <= 1'b1;
			s_rvalid  <= 1'b0;
			s_rdata   <= 32'h0000_0000;
			s_rresp   <= AXI_OK;
		end else if (ce) begin
			if (s_arvalid && s_arready) begin
				s_arready <= 1'b0;
				s_rvalid  <= 1'b1;
				s_rdata   <= rd_ok ? rd_data : 32'h0000_0000;
				s_rresp   <= rd_ok ? AXI_OK : AXI_SLVERR;
			end else if (s_rvalid && s_rready) begin
				s_rvalid  <= 1'b0;
				s_arready <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// *** verilog/lro_top.sv ***
// load rejection output controller: picks each channel's drive value on coupler loss
// assumes set values arrive as a frame with a valid strobe, plus host/bus fault levels from pins
`timescale 1ns/1ps
`default_nettype none
module lro_top import lro_pkg::*; (
	// clock and reset
	input  wire logic                ref_clk,
	input  wire logic                srst,
	input  wire logic                ce,
	// coupler side
	input  wire logic [NCH*DW-1:0]   set_data,
	input  wire logic                set_valid,
	input  wire logic                host_fault,
	input  wire logic                bus_fault,
	// converter side
	output logic [NCH*DW-1:0]        dac_data,
	output logic [2:0]               dac_ch,
	output logic                     dac_load,
	output logic                     fault_active,
	output logic                     irq,
	// axi4-lite
	input  wire logic [7:0]          s_awaddr,
	input  wire logic                s_awvalid,
	output logic                     s_awready,
	input  wire logic [31:0]         s_wdata,
	input  wire logic [3:0]          s_wstrb,
	input  wire logic                s_wvalid,
	output logic                     s_wready,
	output logic [1:0]               s_bresp,
	output logic                     s_bvalid,
	input  wire logic                s_bready,
	input  wire logic [7:0]          s_araddr,
	input  wire logic                s_arvalid,
	output logic                     s_arready,
	output logic [31:0]              s_rdata,
	output logic [1:0]               s_rresp,
	output logic                     s_rvalid,
	input  wire logic                s_rready
);
	logic [1:0]          hf_sync;
	logic [1:0]          bf_sync;
	logic                fault_q;
	lro_cfg_s            shadow;     // what software writes
	lro_cfg_s            active;     // what the logic uses
	logic [2:0]          irq_stat;
	logic [2:0]          irq_mask;
	logic [NCH*DW-1:0]   last_good;
	logic                wr_en;
	logic [7:0]          wr_addr;
	logic [31:0]         wr_data;
	logic [3:0]          wr_strb;
	logic                wr_ok;
	logic [7:0]          rd_addr;
	logic [31:0]         rd_data;
	logic                rd_ok;
	logic                fault_pin;
	logic [2:0]          irq_clr;
	logic [2:0]          irq_ev;
	logic [2:0]          next_irq_stat;
	logic [2:0]          slot;
	logic                slot_pulse;
	logic                scan_done;
	logic                restart;
	logic                fault_rise;
	logic                fault_fall;
	logic [3:0]          widx;
	logic [3:0]          ridx;

	lro_axil u_bus (
		.ref_clk   (ref_clk),
		.srst      (srst),
		.ce        (ce),
		.s_awaddr  (s_awaddr),
		.s_awvalid (s_awvalid),
		.s_awready (s_awready),
		.s_wdata   (s_wdata),
		.s_wstrb   (s_wstrb),
		.s_wvalid  (s_wvalid),
		.s_wready  (s_wready),
		.s_bresp   (s_bresp),
		.s_bvalid  (s_bvalid),
		.s_bready  (s_bready),
		.s_araddr  (s_araddr),
		.s_arvalid (s_arvalid),
		.s_arready (s_arready),
		.s_rdata   (s_rdata),
		.s_rresp   (s_rresp),
		.s_rvalid  (s_rvalid),
		.s_rready  (s_rready),
		.wr_en     (wr_en),
		.wr_addr   (wr_addr),
		.wr_data   (wr_data),
		.wr_strb   (wr_strb),
		.wr_ok     (wr_ok),
		.rd_addr   (rd_addr),
		.rd_data   (rd_data),
		.rd_ok     (rd_ok),
		.rd_en     ()
	);

	// scan timing follows the working set, so a speed change waits for restart
	lro_scan u_scan (
		.ref_clk    (ref_clk),
		.srst       (srst),
		.ce         (ce),
		.fast       (active.fast),
		.en         (active.en),
		.slot       (slot),
		.slot_pulse (slot_pulse),
		.scan_done  (scan_done)
	);

	// fault pins come from the coupler's domain
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			hf_sync <= 2'h0;
			bf_sync <= 2'h0;
			fault_q <= 1'b0;
		end else if (ce) begin
			hf_sync <= {hf_sync[0], host_fault};
			bf_sync <= {bf_sync[0], bus_fault};
			fault_q <= hf_sync[1] | bf_sync[1];
		end
	end

	// edges of the merged fault level feed the sticky status bits
	assign fault_pin  = hf_sync[1] | bf_sync[1];
	assign fault_rise = fault_pin & ~fault_q;
	assign fault_fall = ~fault_pin & fault_q;

	// true for the eight word slots of a per-channel window
	function automatic logic in_win(input logic [7:0] a, input logic [7:0] base);
		return a >= base && a < base + 8'h20;
	endfunction

	// word index inside a per-channel window; only the low three bits are used
	assign widx    = 4'((wr_addr - A_USER0) >> 2);
	assign ridx    = 4'((rd_addr - A_USER0) >> 2);
	// restart is a one-cycle strobe; the bit itself is never stored
	assign restart = wr_en && wr_addr == A_CTRL && wr_strb[0] && wr_data[C_RESTART];

	// status and the output readback window are read only
	always_comb begin
		wr_ok = 1'b1;
		if (!(wr_addr inside {A_CTRL, A_IRQ, A_MASK, A_CFG, A_RANGE})
			&& !in_win(wr_addr, A_USER0)) begin
			wr_ok = 1'b0;
		end
	end

	// shadow settings; only the restart copies them into the working set
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			shadow.fast <= 1'b0;
			shadow.en   <= '1;
			for (int i = 0; i < NCH; i++) begin
				shadow.ch[i].mode <= HOLD_RST;
				shadow.ch[i].cur  <= 1'b0;
				shadow.ch[i].user <= USER_RST;
			end
		end else if (ce && wr_en) begin
			if (wr_addr == A_CTRL && wr_strb[0]) begin
				shadow.fast <= wr_data[C_FAST];
			end
			if (wr_addr == A_CFG) begin
				for (int i = 0; i < NCH; i++) begin
					if (wr_strb[i/2]) begin
						shadow.ch[i].mode <= wr_data[4*i +: 3];
					end
				end
			end
			if (wr_addr == A_RANGE && wr_strb[0]) begin
				shadow.en <= wr_data[7:0];
			end
			if (wr_addr == A_RANGE && wr_strb[1]) begin
				for (int i = 0; i < NCH; i++) begin
					shadow.ch[i].cur <= wr_data[8+i];
				end
			end
			if (in_win(wr_addr, A_USER0)) begin
				if (wr_strb[0]) begin
					shadow.ch[widx[2:0]].user[7:0] <= wr_data[7:0];
				end
				if (wr_strb[1]) begin
					shadow.ch[widx[2:0]].user[15:8] <= wr_data[15:8];
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			active.fast <= 1'b0;
			active.en   <= '1;
			for (int i = 0; i < NCH; i++) begin
				active.ch[i].mode <= HOLD_RST;
				active.ch[i].cur  <= 1'b0;
				active.ch[i].user <= USER_RST;
			end
		end else if (ce && restart) begin
			// the restart write itself carries the new speed, so take it from the bus
			active.en   <= shadow.en;
			active.ch   <= shadow.ch;
			active.fast <= wr_data[C_FAST];
		end
	end

	// last value seen from the coupler while healthy
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			last_good <= '0;
		end else if (ce && set_valid && !fault_q) begin
			last_good <= set_data;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			dac_data     <= '0;
			fault_active <= 1'b0;
		end else if (ce) begin
			fault_active <= fault_q;
			// a frame that arrives while faulted is dropped; the hold value wins
			for (int i = 0; i < NCH; i++) begin
				if (fault_q) begin
					dac_data[i*DW +: DW] <= lro_fault_val(active.ch[i],
						last_good[i*DW +: DW]);
				end else if (set_valid) begin
					dac_data[i*DW +: DW] <= set_data[i*DW +: DW];
				end
			end
		end
	end

	// channel of the slot that follows the one just finished, for the converter
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			dac_ch   <= 3'h0;
			dac_load <= 1'b0;
		end else if (ce) begin
			dac_load <= slot_pulse;
			if (slot_pulse) begin
				dac_ch <= slot;
			end
		end
	end

	// sticky events; a new event in the clearing cycle stays set
	always_comb begin
		irq_clr       = (wr_en && wr_addr == A_IRQ && wr_strb[0]) ? wr_data[2:0] : 3'h0;
		irq_ev        = {scan_done, fault_fall, fault_rise};
		next_irq_stat = (irq_stat & ~irq_clr) | irq_ev;
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			irq_mask <= MASK_RST;
		end else if (ce && wr_en && wr_addr == A_MASK && wr_strb[0]) begin
			irq_mask <= wr_data[2:0];
		end
	end

	// irq is registered so the pin never glitches while status and mask settle
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			irq_stat <= 3'h0;
			irq      <= 1'b0;
		end else if (ce) begin
			irq_stat <= next_irq_stat;
			irq      <= |(next_irq_stat & irq_mask);
		end
	end

	// reads show the written copy of the settings, not the working set, except the speed bit in status, which shows active.fast
	always_comb begin
		rd_ok   = 1'b1;
		rd_data = 32'h0000_0000;
		if (rd_addr == A_CTRL) begin
			rd_data[C_FAST] = shadow.fast;
		end else if (rd_addr == A_STAT) begin
			rd_data = {24'h00_0000, dac_ch, active.fast, 3'h0, fault_q};
		end else if (rd_addr == A_IRQ) begin
			rd_data[2:0] = irq_stat;
		end else if (rd_addr == A_MASK) begin
			rd_data[2:0] = irq_mask;
		end else if (rd_addr == A_CFG) begin
			for (int i = 0; i < NCH; i++) begin
				rd_data[4*i +: 3] = shadow.ch[i].mode;
			end
		end else if (rd_addr == A_RANGE) begin
			for (int i = 0; i < NCH; i++) begin
				rd_data[i]   = shadow.en[i];
				rd_data[8+i] = shadow.ch[i].cur;
			end
		end else if (in_win(rd_addr, A_USER0)) begin
			rd_data[15:0] = shadow.ch[ridx[2:0]].user;
		end else if (in_win(rd_addr, A_OUT0)) begin
			rd_data[15:0] = dac_data[ridx[2:0]*DW +: DW];
		end else begin
			rd_ok = 1'b0;
		end
	end
endmodule
`default_nettype wire

// *** sim/lro_top_sva.sv ***
// port-level checker for the load rejection output controller
// assumes ce is held high; bound to every lro_top
`timescale 1ns/1ps
`default_nettype none
module lro_top_chk import lro_pkg::*; (
	// clock and reset
	input wire logic		ref_clk,
	input wire logic		srst,
	// coupler side
	input wire logic [NCH*DW-1:0]	set_data,
	input wire logic		set_valid,
	input wire logic		host_fault,
	input wire logic		bus_fault,
	// converter side
	input wire logic [NCH*DW-1:0]	dac_data,
	input wire logic		dac_load,
	input wire logic		fault_active,
	input wire logic		irq,
	// axi
	input wire logic		s_awvalid,
	input wire logic		s_awready,
	input wire logic		s_wvalid,
	input wire logic		s_wready,
	input wire logic [1:0]		s_bresp,
	input wire logic		s_bvalid,
	input wire logic		s_bready,
	input wire logic		s_arvalid,
	input wire logic		s_arready,
	input wire logic		s_rvalid
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);
	property p_fault_on;
		(host_fault || bus_fault) [*4] |=> fault_active;
	endproperty
	a_fault_on: assert property (p_fault_on) else $error("fault pin ignored");
	// five quiet samples cover the pin synchroniser and the fault flag
	property p_pass;
		(!host_fault && !bus_fault) [*5] ##0 set_valid |=> dac_data == $past(set_data);
	endproperty
	a_pass: assert property (p_pass) else $error("set value not passed");
	property p_hold;
		(fault_active && !s_awvalid && !s_bvalid) [*4] |=> $stable(dac_data);
	endproperty
	a_hold: assert property (p_hold) else $error("fault value moved");
	property p_b_lat;
		s_awvalid && s_awready && s_wvalid && s_wready |-> ##[1:3] s_bvalid;
	endproperty
	a_b_lat: assert property (p_b_lat) else $error("write response late");
	property p_r_lat;
		s_arvalid && s_arready |-> ##[1:2] s_rvalid;
	endproperty
	a_r_lat: assert property (p_r_lat) else $error("read response late");
	property p_b_hold;
		s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_load;
		dac_load |=> !dac_load;
	endproperty
	a_load: assert property (p_load) else $error("load pulse too long");
	property p_rst;
		$fell(srst) |-> !irq && !fault_active && !s_bvalid && dac_data == '0;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
endmodule
bind lro_top lro_top_chk u_chk (.ref_clk, .srst, .set_data, .set_valid, .host_fault,
	.bus_fault, .dac_data, .dac_load, .fault_active, .irq, .s_awvalid, .s_awready,
	.s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_arvalid, .s_arready, .s_rvalid);
`default_nettype wire

// *** sim/lro_cpl.sv ***
// coupler model: sends set-value frames and raises host or bus fault pins
// assumes its tasks are called right after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module lro_cpl import lro_pkg::*; (
	// clock
	input wire logic		ref_clk,
	// set values and fault pins
	output logic [NCH*DW-1:0]	set_data,
	output logic			set_valid,
	output logic			host_fault,
	output logic			bus_fault
);
	logic [NCH*DW-1:0]	frame;
	logic [NCH*DW-1:0]	noise;
	// outside a frame the lines wander, so a stale word never looks fresh
	assign set_data = set_valid ? frame : noise;
	initial begin
		noise = '0;
		frame = '0;
		set_valid = 1'b0;
		host_fault = 1'b0;
		bus_fault = 1'b0;
	end
	always @(posedge ref_clk) noise <= ~noise;
	task automatic send(input logic [NCH*DW-1:0] d);
		frame <= d;
		set_valid <= 1'b1;
		@(posedge ref_clk);
		set_valid <= 1'b0;
	endtask
	task automatic fault(input logic h, input logic b);
		host_fault <= h;
		bus_fault <= b;
	endtask
endmodule
`default_nettype wire

// *** sim/lro_top_tb.sv ***
// self-checking bench: axi register tasks and the coupler model drive lro_top
// assumes a 200 MHz clock; ce is held high throughout
`timescale 1ns/1ps
`default_nettype none
module lro_top_tb import lro_pkg::*;;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	wire logic [NCH*DW-1:0]	set_data;
	wire logic	set_valid, host_fault, bus_fault;
	logic [NCH*DW-1:0]	dac_data, exp_f;
	logic [2:0]	dac_ch, c0;
	logic	dac_load, fault_active, irq;
	logic [7:0]	s_awaddr = '0, s_araddr = '0;
	logic [31:0]	s_wdata = '0, s_rdata, rdv;
	logic [1:0]	s_bresp, s_rresp, rrs;
	logic	s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
	logic	s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
	int	err_total = 0, checks_done = 0, cyc = 0, n;
	always #2.5 ref_clk = ~ref_clk;
	lro_cpl cpl (.ref_clk, .set_data, .set_valid, .host_fault, .bus_fault);
	lro_top DUT (.ref_clk, .srst, .ce(1'b1), .set_data, .set_valid, .host_fault, .bus_fault,
		.dac_data, .dac_ch, .dac_load, .fault_active, .irq, .s_awaddr, .s_awvalid,
		.s_awready, .s_wdata, .s_wstrb(4'hf), .s_wvalid, .s_wready, .s_bresp, .s_bvalid,
		.s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready);
	function automatic logic [NCH*DW-1:0] z(input logic [31:0] v);
		return (NCH*DW)'(v);
	endfunction
	function automatic logic [NCH*DW-1:0] fr(input logic [3:0] k);
		for (int i = 0; i < NCH; i++) fr[DW*i+:DW] = {k, 4'h0, 4'(i), 4'h5};
	endfunction
	task automatic conclude;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [NCH*DW-1:0] seen, input logic [NCH*DW-1:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		s_awaddr <= a;
		s_wdata <= d;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (s_awready) s_awvalid <= 1'b0;
			if (s_wready) s_wvalid <= 1'b0;
		end while (s_bvalid !== 1'b1);
		s_bready <= 1'b0;
		rrs = s_bresp;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (s_arready) s_arvalid <= 1'b0;
		end while (s_rvalid !== 1'b1);
		s_rready <= 1'b0;
		rdv = s_rdata;
		rrs = s_rresp;
	endtask
	// fault flag waits are bounded by the global cycle ceiling
	task automatic wt(input logic v);
		do @(posedge ref_clk); while (fault_active !== v);
		repeat (3) @(posedge ref_clk);
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 30000) begin
			err_total++;
			conclude;
		end
	end
	initial begin
		repeat (10) @(posedge ref_clk);
		srst <= 1'b0;
		rd(A_CFG);
		chk(z(rdv), z(32'h4444_4444));
		rd(A_USER0 + 8'h0c);
		chk(z(rdv), z(32'h0000_0000));
		rd(8'h18);
		chk((NCH*DW)'({rrs, rdv}), (NCH*DW)'({AXI_SLVERR, 32'h0000_0000}));
		wr(8'h18, 32'h0000_0001);
		chk(z(32'(rrs)), z(32'(AXI_SLVERR)));
		$display("test defaults done");
		cpl.send(fr(4'h1));
		@(posedge ref_clk);
		chk(dac_data, fr(4'h1));
		wr(A_CFG, 32'h4214_3210);
		wr(A_RANGE, 32'h0000_e0ff);
		wr(A_USER0 + 8'h0c, 32'h0000_1234);
		cpl.fault(1'b1, 1'b0);
		wt(1'b1);
		chk(dac_data, z(32'h0000_0000));
		cpl.send(fr(4'h7));
		@(posedge ref_clk);
		chk(dac_data, z(32'h0000_0000));
		cpl.fault(1'b0, 1'b0);
		wt(1'b0);
		cpl.send(fr(4'h2));
		@(posedge ref_clk);
		chk(dac_data, fr(4'h2));
		$display("test settings held done");
		wr(A_CTRL, 32'h0000_0003);
		@(posedge ref_clk);
		cpl.fault(1'b0, 1'b1);
		wt(1'b1);
		exp_f = fr(4'h2);
		exp_f[NCH*DW-1:DW] = {I_ZERO, I_MAX, I_MIN, V_ZERO, 16'h1234, V_MAX, V_MIN};
		chk(dac_data, exp_f);
		rd(A_STAT);
		chk(z(32'({rdv[4], rdv[0]})), z(32'h0000_0003));
		cpl.fault(1'b0, 1'b0);
		wt(1'b0);
		cpl.send(fr(4'h3));
		@(posedge ref_clk);
		chk(dac_data, fr(4'h3));
		$display("test fault values done");
		wr(A_MASK, 32'h0000_0003);
		repeat (2) @(posedge ref_clk);
		chk(z(32'(irq)), z(32'h0000_0001));
		rd(A_IRQ);
		chk(z(32'(rdv[1:0])), z(32'h0000_0003));
		wr(A_IRQ, 32'h0000_0003);
		repeat (2) @(posedge ref_clk);
		chk(z(32'(irq)), z(32'h0000_0000));
		$display("test interrupt done");
		do @(posedge ref_clk); while (dac_load !== 1'b1);
		c0 = dac_ch;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (dac_load !== 1'b1);
		chk(z(n), z(FAST_CYC));
		chk(z(32'(dac_ch)), z(32'(3'(c0 + 3'h1))));
		$display("test conversion slot done");
		conclude;
	end
endmodule
`default_nettype wire
